// file: dv/mod_bit_model.sv
// Purpose: behavioural one-bit modulator feeding the decimator
// Assumes: bit ticks marked by the design bit clock
// Notes:   density is constant, all zeros or all ones
`timescale 1ns/1ps
module mod_bit_model (
  input  wire ref_clk_in,
  input  wire bit_clk_in,
  input  wire level_in,
  output reg  bit_out
);
  initial bit_out = 1'b0;
  // comparator result moves only at a bit tick of the shared reference clock
  always @(posedge ref_clk_in) begin
    if (bit_clk_in) begin
      bit_out <= level_in;
    end
  end
endmodule // mod_bit_model

// file: dv/tb_top.sv
// Purpose: self-checking bench of the word clock timing generator
// Assumes: data tick every 3 clocks, 6.67 MHz data clock
// Notes:   modulator model gives constant density
`timescale 1ns/1ps
bind decimator_word_clock_pwm word_clk_monitor #(.DATA_DIV(DATA_DIV)) mon (.ref_clk_in(ref_clk_in),
  .rst_n_in(rst_n_in), .cfg_load_in(cfg_load_in), .cfg_id_in(cfg_id_in),
  .oversample_factor_in(oversample_factor_in), .pulse_compare_level_in(pulse_compare_level_in),
  .cmp_wr_in(cmp_wr_in), .phi1_out(phi1_out), .phi2_out(phi2_out), .bit_clk_out(bit_clk_out),
  .word_clk_out(word_clk_out), .sample_irq_out(sample_irq_out), .sample_valid_out(sample_valid_out),
  .cascade_out(cascade_out), .owner_id_out(owner_id_out));
module tb_top;
  localparam DD = 3;
  reg ref_clk_in, rst_n_in, cfg_load_in, cfg_id_in, cmp_wr_in, level;
  reg [8:0] oversample_factor_in;
  reg [9:0] pulse_compare_level_in, cmp_data_in;
  wire modulator_bit_in, phi1_out, phi2_out, bit_clk_out, word_clk_out;
  wire sample_irq_out, sample_valid_out, cascade_out, owner_id_out;
  wire [15:0] sample_data_out;
  integer errors, check_count, hi, gap;
  ////////////////////////////////////////
  decimator_word_clock_pwm #(.DATA_DIV(DD)) dut (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .modulator_bit_in(modulator_bit_in), .cfg_load_in(cfg_load_in), .cfg_id_in(cfg_id_in),
    .oversample_factor_in(oversample_factor_in), .pulse_compare_level_in(pulse_compare_level_in),
    .cmp_wr_in(cmp_wr_in), .cmp_data_in(cmp_data_in), .phi1_out(phi1_out), .phi2_out(phi2_out),
    .bit_clk_out(bit_clk_out), .word_clk_out(word_clk_out), .sample_irq_out(sample_irq_out),
    .sample_data_out(sample_data_out), .sample_valid_out(sample_valid_out),
    .cascade_out(cascade_out), .owner_id_out(owner_id_out));
  mod_bit_model modm (.ref_clk_in(ref_clk_in), .bit_clk_in(bit_clk_out), .level_in(level),
    .bit_out(modulator_bit_in));
  ////////////////////////////////////////
  task check(input [31:0] seen, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task close_out;
    begin
      if (errors == 0 && check_count > 0) begin
        $display("Simulation passed");
      end else begin
        $display("Simulation failed");
      end
      $finish;
    end
  endtask
  // next sample, counting word clock high cycles and the gap since the last one
  task wait_irq;
    begin
      hi = 0;
      gap = 0;
      while (gap == 0 || sample_irq_out !== 1'b1) begin
        @(posedge ref_clk_in);
        #1;
        gap = gap + 1;
        if (word_clk_out === 1'b1) begin
          hi = hi + 1;
        end
        if (gap > 4000 * DD) begin
          errors = errors + 1;
          close_out;
        end
      end
    end
  endtask
  task load_cfg(input [8:0] f, input [9:0] c, input id, input w, input lv);
    begin
      @(posedge ref_clk_in);
      cfg_load_in <= 1'b1;
      cfg_id_in <= id;
      oversample_factor_in <= f;
      pulse_compare_level_in <= c;
      cmp_wr_in <= w;
      cmp_data_in <= 10'h005;
      level <= lv;
      @(posedge ref_clk_in);
      cfg_load_in <= 1'b0;
      cmp_wr_in <= 1'b0;
      repeat (2) @(posedge ref_clk_in);
      #1;
      check(owner_id_out, id);
      check(cascade_out, f > 9'h040);
    end
  endtask
  task write_cmp(input [9:0] v);
    begin
      @(posedge ref_clk_in);
      cmp_wr_in <= 1'b1;
      cmp_data_in <= v;
      @(posedge ref_clk_in);
      cmp_wr_in <= 1'b0;
    end
  endtask
  // two discarded samples, then a full valid one
  task settle(input [15:0] exp, input [9:0] c);
    begin
      repeat (2) begin
        wait_irq;
        check(sample_valid_out, 1'b0);
      end
      wait_irq;
      check(sample_valid_out, 1'b1);
      check(sample_data_out, exp);
      check(hi, c * DD);
    end
  endtask
  ////////////////////////////////////////
  task t_factor(input [8:0] f, input lv);
    reg [17:0] exp;
    begin
      exp = lv ? f * f : 18'h00000;
      if (exp > 18'h0ffff) begin
        exp = 18'h0ffff;
      end
      load_cfg(f, {f, 1'b0}, f[7], 1'b0, lv);
      settle(exp[15:0], {f, 1'b0});
      check(gap, 4 * f * DD);
    end
  endtask
  task t_zero;
    integer n;
    integer b;
    begin
      n = 0;
      b = 0;
      load_cfg(9'h020, 10'h000, 1'b0, 1'b0, 1'b1);
      repeat (1200) begin
        @(posedge ref_clk_in);
        #1;
        if (word_clk_out !== 1'b0 || sample_irq_out !== 1'b0) begin
          n = n + 1;
        end
        if (bit_clk_out === 1'b1) begin
          b = b + 1;
        end
      end
      check(n, 0);
      check(b, 300);
      write_cmp(10'h040);
      settle(16'h0400, 10'h040);
    end
  endtask
  task t_runtime;
    begin
      load_cfg(9'h020, 10'h028, 1'b1, 1'b1, 1'b0);
      repeat (3) wait_irq;
      check(hi, 40 * DD);
      repeat (50) @(posedge ref_clk_in);
      write_cmp(10'h064);
      wait_irq;
      check(hi, 40 * DD);
      wait_irq;
      check(hi, 100 * DD);
      check(gap, 128 * DD);
    end
  endtask
  ////////////////////////////////////////
  initial begin
    ref_clk_in = 1'b0;
    forever #25 ref_clk_in = ~ref_clk_in;
  end
  initial begin
    errors = 0;
    check_count = 0;
    rst_n_in = 1'b0;
    cfg_load_in = 1'b0;
    cfg_id_in = 1'b0;
    cmp_wr_in = 1'b0;
    level = 1'b0;
    oversample_factor_in = 9'h040;
    pulse_compare_level_in = 10'h080;
    cmp_data_in = 10'h000;
    repeat (3) @(posedge ref_clk_in);
    #1;
    check({phi1_out, phi2_out, bit_clk_out, word_clk_out, sample_irq_out, sample_valid_out}, 6'h00);
    @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    repeat (4) @(posedge ref_clk_in);
    t_factor(9'h020, 1'b1);
    t_factor(9'h040, 1'b0);
    t_factor(9'h041, 1'b1);
    t_factor(9'h080, 1'b1);
    t_factor(9'h100, 1'b1);
    t_zero;
    t_runtime;
    close_out;
  end
endmodule // tb_top

// file: dv/word_clk_monitor.sv
// Purpose: port checker of the word clock timing generator
// Assumes: bound to the top module, DATA_DIV clocks per data tick
// Notes:   helper registers track the loaded configuration
`timescale 1ns/1ps
module word_clk_monitor #(
  parameter DATA_DIV = 3
) (
  input wire       ref_clk_in,
  input wire       rst_n_in,
  input wire       cfg_load_in,
  input wire       cfg_id_in,
  input wire [8:0] oversample_factor_in,
  input wire [9:0] pulse_compare_level_in,
  input wire       cmp_wr_in,
  input wire       phi1_out,
  input wire       phi2_out,
  input wire       bit_clk_out,
  input wire       word_clk_out,
  input wire       sample_irq_out,
  input wire       sample_valid_out,
  input wire       cascade_out,
  input wire       owner_id_out
);
  localparam int D1 = DATA_DIV;
  localparam int D2 = 2 * DATA_DIV;
  reg [8:0]  fac_q;
  reg [9:0]  cmp_q;
  reg        cmp_ok;
  reg        zero_q;
  reg        seen;
  reg [15:0] gap;
  reg [15:0] hi;
  ////////////////////////////////////////
  always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fac_q <= 9'h040;
      cmp_q <= 10'h080;
      cmp_ok <= 1'b0;
      zero_q <= 1'b0;
      seen <= 1'b0;
      gap <= 16'h0000;
      hi <= 16'h0000;
    end else begin
      if (cfg_load_in) begin
        fac_q <= oversample_factor_in;
        cmp_q <= pulse_compare_level_in;
      end
      cmp_ok <= cfg_load_in | (cmp_ok & ~cmp_wr_in);
      zero_q <= cfg_load_in ? (pulse_compare_level_in == 10'h000) : (zero_q & ~cmp_wr_in);
      seen <= ~cfg_load_in & ~cmp_wr_in & (sample_irq_out | seen);
      gap <= sample_irq_out ? 16'h0001 : gap + 16'h0001;
      hi <= word_clk_out ? hi + 16'h0001 : 16'h0000;
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  a_phase_apart: assert property (
    !(phi1_out && phi2_out)) else $error("phase clocks overlap");
  a_phase_order: assert property (
    $rose(phi1_out) |-> ##D2 $rose(phi2_out) ##D1 $rose(bit_clk_out)) else $error("phase order wrong");
  a_owner_follow: assert property (
    cfg_load_in |=> owner_id_out == $past(cfg_id_in)) else $error("owner id not taken");
  a_stage_count: assert property (
    cfg_load_in ##1 !cfg_load_in |=> cascade_out == (fac_q > 9'h040)) else $error("stage count wrong");
  a_load_restart: assert property (
    cfg_load_in |-> ##2 !word_clk_out) else $error("load did not restart word clock");
  a_irq_on_fall: assert property (
    sample_irq_out && sample_valid_out |-> $past(word_clk_out, 2) && !$past(word_clk_out, 1))
    else $error("sample not tied to word clock fall");
  a_irq_period: assert property (
    sample_irq_out && seen |-> gap == 4 * fac_q * D1) else $error("sample period wrong");
  a_duty_width: assert property (
    $fell(word_clk_out) && cmp_ok && !$past(cfg_load_in, 1) && !$past(cfg_load_in, 2) |-> hi == cmp_q * D1)
    else $error("word clock high time wrong");
  a_zero_quiet: assert property (
    zero_q && $past(zero_q, 3) |-> !word_clk_out && !sample_irq_out) else $error("activity at zero compare");
  c_valid_sample: cover property (sample_irq_out && sample_valid_out);
  c_two_stages: cover property ($rose(cascade_out));
  c_zero_leave: cover property (zero_q ##1 cmp_wr_in);
endmodule // word_clk_monitor

// file: src/count_stage.v
// Purpose: one loadable down-counting stage of the word clock counter
// Assumes: load has priority over count
// Notes:   stages cascade through the zero flag of the lower stage
`timescale 1ns/1ps
`include "word_clock_defines.vh"

module count_stage #(
  parameter W = `STAGE_W
) (
  input  wire         clk_in,
  input  wire         rst_n_in,
  input  wire         load_in,
  input  wire [W-1:0] load_val_in,
  input  wire         dec_in,
  output reg  [W-1:0] count_out,
  output wire         zero_out
);

  assign zero_out = (count_out == {W{1'b0}});

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count_out <= {W{1'b0}};
    end else if (load_in) begin
      count_out <= load_val_in;
    end else if (dec_in) begin
      count_out <= count_out - {{(W-1){1'b0}}, 1'b1};
    end
  end

endmodule // count_stage

// file: src/decimator_word_clock_pwm.v
// Purpose: timing generator and decimator of a delta-sigma converter
// Assumes: one reference clock; data clock is an enable pulse from a divider
// Notes:   word clock counter is one or two 8-bit stages, period four times the factor
`timescale 1ns/1ps
`include "word_clock_defines.vh"

module decimator_word_clock_pwm #(
  parameter             DATA_DIV      = `DATA_CLK_DIV,
  parameter             RESULT_W      = 16,
  parameter             ACC_W         = 18,
  parameter       [8:0] FACTOR_INIT   = `FACTOR_RESET,
  parameter       [9:0] COMPARE_INIT  = `COMPARE_RESET
) (
  input  wire                ref_clk_in,
  input  wire                rst_n_in,
  input  wire                modulator_bit_in,
  input  wire                cfg_load_in,
  input  wire                cfg_id_in,
  input  wire [8:0]          oversample_factor_in,
  input  wire [9:0]          pulse_compare_level_in,
  input  wire                cmp_wr_in,
  input  wire [9:0]          cmp_data_in,
  output reg                 phi1_out,
  output reg                 phi2_out,
  output reg                 bit_clk_out,
  output reg                 word_clk_out,
  output reg                 sample_irq_out,
  output reg  [RESULT_W-1:0] sample_data_out,
  output reg                 sample_valid_out,
  output reg                 cascade_out,
  output reg                 owner_id_out
);

  localparam integer DIV_LAST_FULL = DATA_DIV - 1;
  localparam [7:0]   DIV_LAST      = DIV_LAST_FULL[7:0];
  localparam [2:0]   S_HALT        = `ST_HALT;
  localparam [2:0]   S_SETTLE      = `ST_SETTLE;
  localparam [2:0]   S_RUN         = `ST_RUN;

  reg                 rst_meta;
  reg                 rst_sync_n;
  reg  [7:0]          prescale;
  reg                 data_tick;
  reg  [1:0]          phase;
  reg  [8:0]          factor;
  reg  [9:0]          cmp_active;
  reg  [9:0]          cmp_pending;
  reg  [2:0]          state;
  reg  [2:0]          next_state;
  reg  [1:0]          discard;
  reg  [1:0]          next_discard;
  reg                 sample_pend;
  reg                 valid_pend;
  reg                 restart;
  wire                bit_tick;
  wire [10:0]         period_full;
  wire [9:0]          period_last;
  wire                cascade;
  wire [7:0]          lo_count;
  wire [7:0]          hi_count;
  wire                lo_zero;
  wire                hi_zero;
  wire                terminal;
  wire                lo_load;
  wire                lo_dec;
  wire                hi_dec;
  wire [9:0]          count;
  wire [9:0]          next_count;
  wire [9:0]          next_cmp;
  wire                next_word;
  wire                word_fall;
  wire                sample_evt;
  wire [RESULT_W-1:0] dec_result;

  ////////////////////////////////////////////////////////////////////////////
  // reset release through two flip-flops
  always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_meta   <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta   <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // data clock enable, shared by phase generator and counter stages
  always @(posedge ref_clk_in or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      prescale  <= 8'h00;
      data_tick <= 1'b0;
    end else if (prescale >= DIV_LAST) begin
      prescale  <= 8'h00;
      data_tick <= 1'b1;
    end else begin
      prescale  <= prescale + 8'h01;
      data_tick <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // divide-by-four phase generator and bit clock
  assign bit_tick = data_tick & (phase == `PHASE_LAST);

  always @(posedge ref_clk_in or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      phase       <= 2'h0;
      phi1_out    <= 1'b0;
      phi2_out    <= 1'b0;
      bit_clk_out <= 1'b0;
    end else if (data_tick) begin
      phase       <= phase + 2'h1;
      phi1_out    <= (phase + 2'h1 == `PHI1_PHASE);
      phi2_out    <= (phase + 2'h1 == `PHI2_PHASE);
      bit_clk_out <= (phase + 2'h1 == `PHASE_LAST);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration and compare level
  always @(posedge ref_clk_in or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      factor       <= FACTOR_INIT;
      cmp_pending  <= COMPARE_INIT;
      owner_id_out <= 1'b0;
      restart      <= 1'b0;
    end else begin
      restart <= cfg_load_in;
      if (cfg_load_in) begin
        factor       <= oversample_factor_in;
        cmp_pending  <= pulse_compare_level_in;
        owner_id_out <= cfg_id_in;
      end else if (cmp_wr_in) begin
        cmp_pending <= cmp_data_in;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // word clock counter: one stage up to factor 64, two above
  assign period_full = {factor, 2'b00} - 11'h001;
  assign period_last = period_full[9:0];
  assign cascade     = (factor > `SINGLE_STAGE_MAX);
  assign terminal    = lo_zero & hi_zero;
  assign lo_load     = restart | (data_tick & terminal);
  assign lo_dec      = data_tick & ~terminal;
  assign hi_dec      = lo_dec & lo_zero & cascade;
  assign count       = {hi_count[1:0], lo_count};

  count_stage #(
    .W           (`STAGE_W)
  ) lo_stage (
    .clk_in      (ref_clk_in),
    .rst_n_in    (rst_sync_n),
    .load_in     (lo_load),
    .load_val_in (period_last[7:0]),
    .dec_in      (lo_dec),
    .count_out   (lo_count),
    .zero_out    (lo_zero)
  );

  count_stage #(
    .W           (`STAGE_W)
  ) hi_stage (
    .clk_in      (ref_clk_in),
    .rst_n_in    (rst_sync_n),
    .load_in     (lo_load),
    .load_val_in (cascade ? {6'h00, period_last[9:8]} : 8'h00),
    .dec_in      (hi_dec),
    .count_out   (hi_count),
    .zero_out    (hi_zero)
  );

  ////////////////////////////////////////////////////////////////////////////
  // pulse output: high while the count is below the compare level
  assign next_count = terminal ? period_last : count - 10'h001;
  assign next_cmp   = terminal ? cmp_pending : cmp_active;
  assign next_word  = (next_count < next_cmp);
  assign word_fall  = data_tick & word_clk_out & ~next_word;
  assign sample_evt = word_fall & terminal & ~restart;

  always @(posedge ref_clk_in or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cmp_active   <= COMPARE_INIT;
      word_clk_out <= 1'b0;
      cascade_out  <= 1'b0;
    end else begin
      cascade_out <= cascade;
      if (restart) begin
        cmp_active   <= cmp_pending;
        word_clk_out <= 1'b0;
      end else if (data_tick) begin
        cmp_active   <= next_cmp;
        word_clk_out <= next_word;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // decimator clocked by bit tick and word clock falling edge
  sinc2_decimator #(
    .ACC_W      (ACC_W),
    .RESULT_W   (RESULT_W)
  ) decimator (
    .clk_in     (ref_clk_in),
    .rst_n_in   (rst_sync_n),
    .clear_in   (restart),
    .bit_en_in  (bit_tick),
    .bit_in     (modulator_bit_in),
    .dump_en_in (sample_evt),
    .result_out (dec_result)
  );

  ////////////////////////////////////////////////////////////////////////////
  // sample qualifier: halted at zero compare, two discarded after restart
  always @* begin
    next_state   = state;
    next_discard = discard;
    case (state)
      S_HALT: begin
        if (cmp_active != 10'h000) begin
          next_state   = S_SETTLE;
          next_discard = `DISCARD_COUNT;
        end
      end
      S_SETTLE: begin
        if (cmp_active == 10'h000) begin
          next_state = S_HALT;
        end else if (sample_evt) begin
          next_discard = discard - 2'h1;
          if (discard == 2'h1) begin
            next_state = S_RUN;
          end
        end
      end
      S_RUN: begin
        if (cmp_active == 10'h000) begin
          next_state = S_HALT;
        end
      end
      default: begin
        next_state   = S_HALT;
        next_discard = 2'h0;
      end
    endcase
    if (restart) begin
      next_state   = S_SETTLE;
      next_discard = `DISCARD_COUNT;
    end
  end

  always @(posedge ref_clk_in or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state   <= S_SETTLE;
      discard <= `DISCARD_COUNT;
    end else begin
      state   <= next_state;
      discard <= next_discard;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // result and interrupt, one cycle after the dump edge
  always @(posedge ref_clk_in or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      sample_pend      <= 1'b0;
      valid_pend       <= 1'b0;
      sample_irq_out   <= 1'b0;
      sample_valid_out <= 1'b0;
      sample_data_out  <= {RESULT_W{1'b0}};
    end else begin
      sample_pend    <= sample_evt;
      valid_pend     <= (state == S_RUN);
      sample_irq_out <= sample_pend;
      if (sample_pend) begin
        sample_data_out  <= dec_result;
        sample_valid_out <= valid_pend;
      end
    end
  end

endmodule // decimator_word_clock_pwm

// file: src/sinc2_decimator.v
// Purpose: second-order integrate and dump decimation filter
// Assumes: bit_en_in marks one-bit rate, dump_en_in the word clock falling edge
// Notes:   integrators wrap; differences recover the true sum
`timescale 1ns/1ps
`include "word_clock_defines.vh"

module sinc2_decimator #(
  parameter ACC_W    = 18,
  parameter RESULT_W = 16
) (
  input  wire                clk_in,
  input  wire                rst_n_in,
  input  wire                clear_in,
  input  wire                bit_en_in,
  input  wire                bit_in,
  input  wire                dump_en_in,
  output reg  [RESULT_W-1:0] result_out
);

  reg  [ACC_W-1:0] integ1;
  reg  [ACC_W-1:0] integ2;
  reg  [ACC_W-1:0] hold1;
  reg  [ACC_W-1:0] hold2;
  wire [ACC_W-1:0] diff1;
  wire [ACC_W-1:0] diff2;
  wire             over;

  assign diff1 = integ2 - hold1;
  assign diff2 = diff1 - hold2;
  assign over  = |diff2[ACC_W-1:RESULT_W];

  ////////////////////////////////////////////////////////////////////////////
  // double integrator at bit rate, double differentiator at word rate
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      integ1     <= {ACC_W{1'b0}};
      integ2     <= {ACC_W{1'b0}};
      hold1      <= {ACC_W{1'b0}};
      hold2      <= {ACC_W{1'b0}};
      result_out <= {RESULT_W{1'b0}};
    end else if (clear_in) begin
      integ1 <= {ACC_W{1'b0}};
      integ2 <= {ACC_W{1'b0}};
      hold1  <= {ACC_W{1'b0}};
      hold2  <= {ACC_W{1'b0}};
    end else begin
      if (bit_en_in) begin
        integ1 <= integ1 + {{(ACC_W-1){1'b0}}, bit_in};
        integ2 <= integ2 + integ1;
      end
      if (dump_en_in) begin
        hold1      <= integ2;
        hold2      <= diff1;
        result_out <= over ? {RESULT_W{1'b1}} : diff2[RESULT_W-1:0];
      end
    end
  end

endmodule // sinc2_decimator

// file: src/word_clock_defines.vh
// Purpose: shared constants of the converter timing generator
// Assumes: 20 MHz reference clock
// Notes:   included by bare name
`ifndef WORD_CLOCK_DEFINES_VH
`define WORD_CLOCK_DEFINES_VH

// clock rates in kHz
`define REF_CLK_KHZ          20000
`define DATA_CLK_MAX_KHZ     8000
// least whole divide that keeps the data clock at or below its maximum
`define DATA_CLK_DIV         ((`REF_CLK_KHZ + `DATA_CLK_MAX_KHZ - 1) / `DATA_CLK_MAX_KHZ)

// fixed phase generator and counter stages
`define PHASE_LAST           2'h3
`define PHI1_PHASE           2'h0
`define PHI2_PHASE           2'h2
`define STAGE_W              8
`define SINGLE_STAGE_MAX     9'h040

// reset values
`define FACTOR_RESET         9'h040
`define COMPARE_RESET        10'h080
`define DISCARD_COUNT        2'h2

// one-hot states of the sample qualifier
`define ST_HALT              3'h1
`define ST_SETTLE            3'h2
`define ST_RUN               3'h4

`endif
